/* File: ard_pkg.sv */
// Purpose: shared constants for the rate and decimation control block
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package ard_pkg;
   localparam logic [7:0]  RATE_CFG_OFS     = 8'h17;
   localparam logic [7:0]  IRQ_TRIG_CFG_OFS = 8'h18;
   localparam logic [7:0]  MODE_CFG_OFS     = 8'h20;
   localparam logic [7:0]  STATUS_OFS       = 8'h24;
   localparam logic [7:0]  RATE_CFG_RST     = 8'h00;
   localparam logic [7:0]  IRQ_TRIG_CFG_RST = 8'h01;
   localparam logic [3:0]  MODE_CFG_RST     = 4'h0;
   localparam logic [3:0]  CODE_MAX         = 4'hC;
   localparam logic [1:0]  PM_FLEX          = 2'h2;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
   localparam int          WAKE_MSB         = 7;
   localparam int          WAKE_LSB         = 4;
   localparam int          SLEEP_MSB        = 3;
   localparam int          SLEEP_LSB        = 0;
   localparam int          MODE_MSB         = 3;
   localparam int          NUM_CODES        = 16;
   // interrupt and trigger configuration field positions
   localparam int          TRIG_MODE_BIT    = 7;
   localparam int          WAKE_WT_BIT      = 6;
   localparam int          WAKE_OT_BIT      = 5;
   localparam int          WAKE_SRC_ORIENTATION_BIT  = 4;
   localparam int          DATA_READY_BIT   = 3;
   localparam int          TRIG_IN_BIT      = 2;
   localparam int          DRIVE_TYPE_BIT   = 1;
   localparam int          POLARITY_BIT     = 0;
   localparam logic [12:0] AVG_MAX          = 13'h1000;
   localparam logic [31:0] RATE_MIN_MHZ     = 32'h0000_030D;
   localparam logic [31:0] MEAS_MAX_CYC     = 32'h07A1_2000;
   // rate in milli-hertz at code 0; halves with each code step up to code 12
   localparam logic [31:0] RATE_TOP_MHZ     = 32'h0030_D400;
   // measurement time per acquisition, in ns
   localparam logic [31:0] ACQ_TIME_NS      = 32'h0004_C4B4;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam logic [31:0] ACQ_TIME_CYC     =
      32'(ACQ_TIME_NS / CLK_PERIOD_NS);
   typedef enum logic [1:0] {
      ARD_IDLE = 2'b01,
      ARD_DATA = 2'b10
   } ard_bus_state_t;
endpackage : ard_pkg

/* File: ard_decode.sv */
// Purpose: decodes one 4-bit rate or averaging code
// Assumes: code above 1100 saturates
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module ard_decode (
   input  wire logic [3:0]  code_in,
   input  wire logic        flex_in,
   output logic      [12:0] avg_count_out,
   output logic      [31:0] rate_mhz_out,
   output logic      [31:0] meas_cycles_out
);
   logic [3:0] sat_code;
   assign sat_code = (code_in > ard_pkg::CODE_MAX) ?
                     ard_pkg::CODE_MAX : code_in;
   assign avg_count_out = 13'(13'h0001 << sat_code);
   // flexible mode rate is set by idle time elsewhere, so report zero
   assign rate_mhz_out = flex_in ? 32'h0000_0000 :
                         (ard_pkg::RATE_TOP_MHZ >> sat_code);
   assign meas_cycles_out = 32'(ard_pkg::ACQ_TIME_CYC *
                                32'(avg_count_out));
endmodule : ard_decode
`default_nettype wire

/* File: ard_top.sv */
// Purpose: wake/sleep rate and averaging decode with config registers
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   decode outputs follow the registers combinationally
//
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module ard_top (
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic      [31:0] hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   output logic      [12:0] wake_avg_count_out,
   output logic      [31:0] wake_rate_mhz_out,
   output logic      [31:0] wake_meas_cycles_out,
   output logic      [12:0] sleep_avg_count_out,
   output logic      [31:0] sleep_rate_mhz_out,
   output logic      [31:0] sleep_meas_cycles_out,
   output logic      [7:0]  interrupt_trigger_config_out
);
   logic [7:0]  rate_config_q;
   logic [7:0]  irq_cfg_q;
   logic [3:0]  mode_q;
   logic [7:0]  addr_q;
   logic        wr_q;
   ard_pkg::ard_bus_state_t state_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   wire        active;
   wire        accept;
   wire        wr_phase;
   wire        flex_wake;
   wire        flex_sleep;
   wire        cfg_locked;
   wire [3:0]  wake_code;
   wire [3:0]  sleep_code;
   wire [7:0]  addr_lo;
   wire        standby;
   wire        trig_in_on;
   wire        wr_rate;
   wire        wr_irq;
   wire        wr_mode;
   wire [7:0]  wr_byte;
   wire [7:0]  rate_cfg_now;
   wire [7:0]  irq_cfg_now;
   wire [3:0]  mode_now;
   wire        locked_now;
   wire        rd_take;
   wire        trigger_acquire_mode;
   wire        wake_src_within_threshold;
   wire        wake_src_outside_threshold;
   wire        wake_src_orientation;
   wire        data_ready_pulse_sel;
   wire        second_irq_pin_function;
   wire        irq_output_drive_type;
   wire        irq_polarity;

   assign active = hsel_in && hready_in &&
                   (htrans_in == ard_pkg::HTRANS_NONSEQ ||
                    htrans_in == ard_pkg::HTRANS_SEQ);
   assign accept   = active;
   assign addr_lo  = haddr_in[7:0];
   assign wr_phase = (state_q == ard_pkg::ARD_DATA) && wr_q;

   // mode bits: [1:0] wake power mode, [3:2] sleep power mode
   assign flex_wake  = (mode_q[1:0] == ard_pkg::PM_FLEX);
   assign flex_sleep = (mode_q[3:2] == ard_pkg::PM_FLEX);
   assign wake_code  = rate_config_q[ard_pkg::WAKE_MSB:ard_pkg::WAKE_LSB];
   assign sleep_code =
      rate_config_q[ard_pkg::SLEEP_MSB:ard_pkg::SLEEP_LSB];
   // sampling is out of scope; standby is assumed, trigger input is
   // the second irq pin function bit
   assign standby    = 1'b1;
   assign trig_in_on = irq_cfg_q[ard_pkg::TRIG_IN_BIT];
   // hardware does not block writes; software must obey the lock
   assign cfg_locked = !standby || trig_in_on;

   // named fields of the interrupt and trigger configuration
   assign trigger_acquire_mode       = irq_cfg_q[ard_pkg::TRIG_MODE_BIT];
   assign wake_src_within_threshold  = irq_cfg_q[ard_pkg::WAKE_WT_BIT];
   assign wake_src_outside_threshold = irq_cfg_q[ard_pkg::WAKE_OT_BIT];
   assign wake_src_orientation       = irq_cfg_q[ard_pkg::WAKE_SRC_ORIENTATION_BIT];
   assign data_ready_pulse_sel       = irq_cfg_q[ard_pkg::DATA_READY_BIT];
   assign second_irq_pin_function    = irq_cfg_q[ard_pkg::TRIG_IN_BIT];
   assign irq_output_drive_type      = irq_cfg_q[ard_pkg::DRIVE_TYPE_BIT];
   assign irq_polarity               = irq_cfg_q[ard_pkg::POLARITY_BIT];

   // a read taken right behind a write to the same register would see
   // the old value, so the data phase write is forwarded to the read
   assign wr_byte      = hwdata_in[7:0];
   assign wr_rate      = wr_phase && (addr_q == ard_pkg::RATE_CFG_OFS);
   assign wr_irq       = wr_phase && (addr_q == ard_pkg::IRQ_TRIG_CFG_OFS);
   assign wr_mode      = wr_phase && (addr_q == ard_pkg::MODE_CFG_OFS);
   assign rate_cfg_now = wr_rate ? wr_byte : rate_config_q;
   assign irq_cfg_now  = wr_irq ? wr_byte : irq_cfg_q;
   assign mode_now     = wr_mode ? hwdata_in[ard_pkg::MODE_MSB:0] : mode_q;
   assign locked_now   = !standby || irq_cfg_now[ard_pkg::TRIG_IN_BIT];
   assign rd_take      = accept && !hwrite_in;

   always_comb begin
      rdata_d = 32'h0000_0000;
      case (addr_lo)
         ard_pkg::RATE_CFG_OFS:     rdata_d = {24'h00_0000, rate_cfg_now};
         ard_pkg::IRQ_TRIG_CFG_OFS: rdata_d = {24'h00_0000, irq_cfg_now};
         ard_pkg::MODE_CFG_OFS:     rdata_d = {28'h000_0000, mode_now};
         ard_pkg::STATUS_OFS:       rdata_d = {31'h0000_0000, locked_now};
         default:                   rdata_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q <= ard_pkg::ARD_IDLE;
         addr_q  <= 8'h00;
         wr_q    <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         state_q <= accept ? ard_pkg::ARD_DATA : ard_pkg::ARD_IDLE;
         if (accept) begin
            addr_q <= addr_lo;
            wr_q   <= hwrite_in;
         end
         if (rd_take) begin
            rdata_q <= rdata_d;
         end
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rate_config_q <= ard_pkg::RATE_CFG_RST;
         irq_cfg_q     <= ard_pkg::IRQ_TRIG_CFG_RST;
         mode_q        <= ard_pkg::MODE_CFG_RST;
      end else begin
         if (wr_rate) begin
            rate_config_q <= wr_byte;
         end
         if (wr_irq) begin
            irq_cfg_q <= wr_byte;
         end
         if (wr_mode) begin
            mode_q <= hwdata_in[ard_pkg::MODE_MSB:0];
         end
      end
   end

   assign hrdata_out    = rdata_q;
   assign hreadyout_out = 1'b1;
   assign hresp_out     = 1'b0;
   assign interrupt_trigger_config_out = irq_cfg_q;

   ard_decode u_wake (
      .code_in         (wake_code),
      .flex_in         (flex_wake),
      .avg_count_out   (wake_avg_count_out),
      .rate_mhz_out    (wake_rate_mhz_out),
      .meas_cycles_out (wake_meas_cycles_out)
   );

   ard_decode u_sleep (
      .code_in         (sleep_code),
      .flex_in         (flex_sleep),
      .avg_count_out   (sleep_avg_count_out),
      .rate_mhz_out    (sleep_rate_mhz_out),
      .meas_cycles_out (sleep_meas_cycles_out)
   );

   // assertions
   sequence s_write_to(logic [7:0] ofs);
      state_q == ard_pkg::ARD_DATA && wr_q && addr_q == ofs;
   endsequence

   sequence s_read_of(logic [7:0] ofs);
      state_q == ard_pkg::ARD_DATA && !wr_q && addr_q == ofs;
   endsequence

   sequence s_write_other;
      wr_phase && addr_q != ard_pkg::RATE_CFG_OFS &&
         addr_q != ard_pkg::IRQ_TRIG_CFG_OFS &&
         addr_q != ard_pkg::MODE_CFG_OFS;
   endsequence

   a_hp_rate_top: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (!flex_wake && wake_code == 4'h0) |->
         wake_rate_mhz_out == ard_pkg::RATE_TOP_MHZ)
      else $error("wake rate at code 0 wrong");
   a_hp_avg_sat: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (wake_code > ard_pkg::CODE_MAX) |->
         wake_avg_count_out == ard_pkg::AVG_MAX)
      else $error("wake averaging not saturated");
   a_hp_rate_sat: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (!flex_sleep && sleep_code >= ard_pkg::CODE_MAX) |->
         sleep_rate_mhz_out == ard_pkg::RATE_MIN_MHZ)
      else $error("sleep slowest rate wrong");
   a_hp_wake_min: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (!flex_wake && wake_code >= ard_pkg::CODE_MAX) |->
         wake_rate_mhz_out == ard_pkg::RATE_MIN_MHZ)
      else $error("wake slowest rate wrong");
   a_flex_avg_pow: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (sleep_code <= ard_pkg::CODE_MAX) |->
         sleep_avg_count_out == 13'(13'h0001 << sleep_code))
      else $error("sleep averaging count wrong");
   a_flex_rate_zero: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      flex_wake |-> wake_rate_mhz_out == 32'h0000_0000)
      else $error("flexible wake rate not zero");
   a_flex_time_max: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (wake_code >= ard_pkg::CODE_MAX) |->
         wake_meas_cycles_out == ard_pkg::MEAS_MAX_CYC)
      else $error("max measurement time wrong");
   a_flex_time_sat: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      (sleep_code == 4'hF) |->
         sleep_meas_cycles_out == ard_pkg::MEAS_MAX_CYC)
      else $error("saturated measurement time wrong");

   // per code tables, built from the rules rather than the decoder
   for (genvar k = 0; k < ard_pkg::NUM_CODES; k++) begin : g_code_chk
      localparam int SAT_K = (k > int'(ard_pkg::CODE_MAX)) ?
                             int'(ard_pkg::CODE_MAX) : k;
      localparam logic [12:0] AVG_K  = 13'(1 << SAT_K);
      localparam logic [31:0] RATE_K = ard_pkg::RATE_TOP_MHZ >> SAT_K;
      localparam logic [31:0] MEAS_K =
         32'(ard_pkg::ACQ_TIME_CYC * 32'(AVG_K));
      a_avg_table: assert property (@(posedge clk_in)
         disable iff (!reset_n_in)
         (wake_code == 4'(k)) |-> wake_avg_count_out == AVG_K)
         else $error("wake averaging table wrong");
      a_rate_table: assert property (@(posedge clk_in)
         disable iff (!reset_n_in)
         (!flex_sleep && sleep_code == 4'(k)) |->
            sleep_rate_mhz_out == RATE_K)
         else $error("sleep rate table wrong");
      a_meas_table: assert property (@(posedge clk_in)
         disable iff (!reset_n_in)
         (sleep_code == 4'(k)) |-> sleep_meas_cycles_out == MEAS_K)
         else $error("sleep measurement time table wrong");
   end

   a_irq_cfg_write: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_write_to(ard_pkg::IRQ_TRIG_CFG_OFS) |=>
         irq_cfg_q == $past(hwdata_in[7:0]))
      else $error("irq config write lost");
   a_irq_fields: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_write_to(ard_pkg::IRQ_TRIG_CFG_OFS) |=>
         {trigger_acquire_mode, wake_src_within_threshold,
          wake_src_outside_threshold, wake_src_orientation,
          data_ready_pulse_sel, second_irq_pin_function,
          irq_output_drive_type, irq_polarity} == $past(hwdata_in[7:0]))
      else $error("irq config field order wrong");
   a_nibble_split: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_write_to(ard_pkg::RATE_CFG_OFS) |=>
         wake_code == $past(hwdata_in[7:4]) &&
         sleep_code == $past(hwdata_in[3:0]))
      else $error("rate nibble split wrong");
   a_lock_status: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      irq_cfg_q[ard_pkg::TRIG_IN_BIT] |-> cfg_locked)
      else $error("lock status missing");

   // read data must show the register as it stands in the data phase
   a_rd_rate: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_read_of(ard_pkg::RATE_CFG_OFS) |->
         hrdata_out == {24'h00_0000, rate_config_q})
      else $error("rate config read wrong");
   a_rd_irq: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_read_of(ard_pkg::IRQ_TRIG_CFG_OFS) |->
         hrdata_out == {24'h00_0000, irq_cfg_q})
      else $error("irq config read wrong");
   a_rd_mode: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_read_of(ard_pkg::MODE_CFG_OFS) |->
         hrdata_out == {28'h000_0000, mode_q})
      else $error("mode read wrong");
   a_rd_lock: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_read_of(ard_pkg::STATUS_OFS) |->
         hrdata_out == {31'h0000_0000, cfg_locked})
      else $error("lock status read wrong");
   a_unmapped_wr: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      s_write_other |=> $stable(rate_config_q) && $stable(irq_cfg_q) &&
         $stable(mode_q))
      else $error("unmapped write changed a register");
   a_rdata_hold: assert property (@(posedge clk_in)
      disable iff (!reset_n_in)
      !rd_take |=> $stable(hrdata_out))
      else $error("read data moved without a read");
endmodule : ard_top
`default_nettype wire

/* File: tb.sv */
// Purpose: self-checking bench for ard_top
// Assumes: zero wait slave, offsets used as byte addresses
// Notes:   decode outputs are judged two edges after each rate config write in t_codes
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_in       = 1'b0;
   logic        reset_n_in   = 1'b0;
   logic        hsel_in      = 1'b0;
   logic [31:0] haddr_in     = 32'h0000_0000;
   logic [1:0]  htrans_in    = 2'h0;
   logic        hwrite_in    = 1'b0;
   logic [2:0]  hsize_in     = 3'h2;
   logic [31:0] hwdata_in    = 32'h0000_0000;
   logic [31:0] hrdata_out;
   logic        hreadyout_out;
   logic        hresp_out;
   logic [12:0] wake_avg_count_out;
   logic [31:0] wake_rate_mhz_out;
   logic [31:0] wake_meas_cycles_out;
   logic [12:0] sleep_avg_count_out;
   logic [31:0] sleep_rate_mhz_out;
   logic [31:0] sleep_meas_cycles_out;
   logic [7:0]  interrupt_trigger_config_out;
   logic [31:0] rd;
   int          num_errors   = 0;
   int          total_checks = 0;
   always #5 clk_in = ~clk_in;
   ard_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .hsel_in(hsel_in),
      .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
      .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
      .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out), .wake_avg_count_out(wake_avg_count_out),
      .wake_rate_mhz_out(wake_rate_mhz_out),
      .wake_meas_cycles_out(wake_meas_cycles_out),
      .sleep_avg_count_out(sleep_avg_count_out),
      .sleep_rate_mhz_out(sleep_rate_mhz_out),
      .sleep_meas_cycles_out(sleep_meas_cycles_out),
      .interrupt_trigger_config_out(interrupt_trigger_config_out));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // master waits on hready, never on a fixed count
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_in   <= 1'b1;
      haddr_in  <= {24'h00_0000, a};
      hwrite_in <= w;
      htrans_in <= ard_pkg::HTRANS_NONSEQ;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      htrans_in <= 2'h0;
      hwdata_in <= d;
      do @(posedge clk_in); while (hreadyout_out !== 1'b1);
      rd = hrdata_out;
      chk("hresp", 32'h0000_0000, {31'h0, hresp_out});
   endtask : bus
   task automatic dchk(input logic [3:0] c, input logic f, input logic [12:0] n,
                       input logic [31:0] r, input logic [31:0] m);
      logic [3:0] s;
      s = (c > 4'hC) ? 4'hC : c;
      chk("avg_count", 32'h0000_0001 << s, {19'h0, n});
      chk("rate_mhz", f ? 32'h0000_0000 : (32'h0030_D400 >> s), r);
      if (f) chk("meas_cycles", (32'h0000_0001 << s) * 32'h0000_7A12, m);
   endtask : dchk
   task automatic t_reset();
      bus(1'b0, 8'h18, 32'h0000_0000);
      chk("irq_cfg_rd", 32'h0000_0001, rd);
      chk("irq_cfg_out", 32'h0000_0001, {24'h0, interrupt_trigger_config_out});
      bus(1'b0, 8'h17, 32'h0000_0000);
      chk("rate_cfg_rd", 32'h0000_0000, rd);
      dchk(4'h0, 1'b0, wake_avg_count_out, wake_rate_mhz_out, wake_meas_cycles_out);
   endtask : t_reset
   // mode register read back, then lock status with trigger pin on/off
   task automatic t_mode();
      bus(1'b1, 8'h20, 32'h0000_000A);
      bus(1'b0, 8'h20, 32'h0000_0000);
      chk("mode_rd", 32'h0000_000A, rd);
      bus(1'b1, 8'h18, 32'h0000_0005);
      bus(1'b0, 8'h24, 32'h0000_0000);
      chk("lock_rd", 32'h0000_0001, rd);
      bus(1'b1, 8'h18, 32'h0000_0001);
      bus(1'b0, 8'h24, 32'h0000_0000);
      chk("unlock_rd", 32'h0000_0000, rd);
   endtask : t_mode
   // unmapped write must not alias onto the config register
   task automatic t_irq();
      bus(1'b1, 8'h18, 32'h0000_00FE);
      bus(1'b1, 8'h30, 32'h0000_0055);
      bus(1'b0, 8'h30, 32'h0000_0000);
      chk("unmapped_rd", 32'h0000_0000, rd);
      bus(1'b0, 8'h18, 32'h0000_0000);
      chk("irq_cfg_rd", 32'h0000_00FE, rd);
      chk("irq_cfg_out", 32'h0000_00FE, {24'h0, interrupt_trigger_config_out});
      bus(1'b1, 8'h18, 32'h0000_0001);
   endtask : t_irq
   // wake and sleep get opposite codes so a swapped nibble shows
   task automatic t_codes(input logic f);
      logic [3:0] c;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         bus(1'b1, 8'h17, {24'h00_0000, c, ~c});
         repeat (2) @(posedge clk_in);
         dchk(c, f, wake_avg_count_out, wake_rate_mhz_out, wake_meas_cycles_out);
         dchk(~c, f, sleep_avg_count_out, sleep_rate_mhz_out, sleep_meas_cycles_out);
      end
   endtask : t_codes
   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (5000) @(posedge clk_in);
      num_errors++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      t_reset();
      t_irq();
      t_codes(1'b0);
      t_mode();
      t_codes(1'b1);
      results();
   end
endmodule : tb
`default_nettype wire
